// [bench/rfp_cmd_checker.sv]
`timescale 1ns/10ps
module rfp_cmd_checker #(
  parameter logic [7:0] TX_REGS = 8'h08,
  parameter logic [7:0] RX_REGS = 8'h08,
  parameter logic [7:0] GT_REGS = 8'h10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  // answer and status
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic exc,
  input wire logic done,
  input wire logic busy,
  // stored writes
  input wire logic nv_wr_en,
  input wire logic [5:0] nv_wr_profile,
  input wire logic [7:0] nv_wr_reg,
  input wire logic [31:0] nv_wr_data,
  // loads
  input wire logic load_tx_go,
  input wire logic [7:0] load_tx_code,
  input wire logic load_rx_go,
  input wire logic [7:0] load_rx_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [5:0] slot_of(input logic [7:0] c);
    return c[7] ? c[5:0] + 6'h1D : c[5:0];
  endfunction : slot_of
  function automatic logic [7:0] slot_cnt(input logic [5:0] s);
    if (s == 6'h1C || s == 6'h39) return GT_REGS;
    return (s > 6'h1C) ? RX_REGS : TX_REGS;
  endfunction : slot_cnt
  ////////////////////////////////////////
  sequence s_reject;
    rx_end ##1 exc;
  endsequence
  sequence s_wr_more;
    nv_wr_en && !done;
  endsequence
  a_reject_done: assert property (s_reject |-> ##[0:2] done)
    else $error("rejected command did not finish");
  a_size_answer: assert property (rsp_valid |-> $past(rx_valid) &&
    rsp_byte == slot_cnt(slot_of($past(rx_byte)))) else $error("size answer wrong");
  a_write_clean: assert property (nv_wr_en |-> !exc && busy)
    else $error("write during failed command");
  a_write_slot: assert property (nv_wr_en |-> nv_wr_profile <= 6'h39)
    else $error("write slot out of range");
  a_write_reg: assert property (nv_wr_en |-> nv_wr_reg < slot_cnt(nv_wr_profile))
    else $error("write register outside profile");
  a_write_burst: assert property (s_wr_more |=> nv_wr_en)
    else $error("write burst broken");
  a_load_tx_ok: assert property (load_tx_go |-> ##[0:1] load_tx_code <= 8'h1C)
    else $error("tx load with bad code");
  a_load_rx_ok: assert property (load_rx_go |-> ##[0:1]
    load_rx_code inside {[8'h80:8'h9C]}) else $error("rx load with bad code");
endmodule : rfp_cmd_checker

bind rfp_cmd_core rfp_cmd_checker #(.TX_REGS(TX_REGS), .RX_REGS(RX_REGS), .GT_REGS(GT_REGS))
  chk_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
  .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .exc(exc), .done(done), .busy(busy),
  .nv_wr_en(nv_wr_en), .nv_wr_profile(nv_wr_profile), .nv_wr_reg(nv_wr_reg),
  .nv_wr_data(nv_wr_data), .load_tx_go(load_tx_go), .load_tx_code(load_tx_code),
  .load_rx_go(load_rx_go), .load_rx_code(load_rx_code));

// [bench/rfp_host_model.sv]
`timescale 1ns/10ps
module rfp_host_model (
  // clock
  input wire logic clk,
  // command stream
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_end
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_end = 1'b0;
  end
  // whole frame, then end marker; idle byte never repeats
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = q[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_end = 1'b1;
    @(negedge clk);
    rx_end = 1'b0;
  endtask : send
endmodule : rfp_host_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_end, rsp_valid, exc, done, busy, nv_wr_en, load_tx_go, load_rx_go;
  logic [7:0] rx_byte, rsp_byte, nv_wr_reg, load_tx_code, load_rx_code;
  logic [5:0] nv_wr_profile;
  logic [31:0] nv_wr_data;
  int bad_count = 0;
  int n_compared = 0;
  int n_rsp = 0;
  int n_ltx = 0;
  int n_lrx = 0;
  logic got_exc;
  logic [45:0] wr_q[$];
  logic [7:0] q[$];
  always #25 clk = ~clk;
  rfp_cmd_core #(.TX_REGS(8'h06), .RX_REGS(8'h0A), .GT_REGS(8'h10)) dut_u (.clk, .rst_n,
    .rx_valid, .rx_byte, .rx_end, .rsp_valid, .rsp_byte, .exc, .done, .busy, .nv_wr_en,
    .nv_wr_profile, .nv_wr_reg, .nv_wr_data, .load_tx_go, .load_tx_code, .load_rx_go,
    .load_rx_code);
  rfp_host_model host_u (.clk, .rx_valid, .rx_byte, .rx_end);
  always @(negedge clk) begin
    if (nv_wr_en === 1'b1) wr_q.push_back({nv_wr_profile, nv_wr_reg, nv_wr_data});
    if (rsp_valid === 1'b1) n_rsp++;
    if (load_tx_go === 1'b1) n_ltx++;
    if (load_rx_go === 1'b1) n_lrx++;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic add(input logic [7:0] c, input logic [7:0] r, input logic [31:0] v);
    q.push_back(c);
    q.push_back(r);
    for (int i = 0; i < 4; i++) q.push_back(v[8*i+:8]);
  endtask : add
  // send frame in q, wait for done, let its pulse pass
  task automatic run();
    int k;
    wr_q.delete();
    n_rsp = 0;
    n_ltx = 0;
    n_lrx = 0;
    host_u.send(q);
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      bad_count++;
      conclude();
    end
    got_exc = exc;
    @(negedge clk);
  endtask : run
  ////////////////////////////////////////
  task automatic t_size();
    logic [7:0] c[6] = '{8'h00, 8'h1C, 8'h80, 8'h9C, 8'h13, 8'h95};
    logic [7:0] b[5] = '{8'h1D, 8'h7F, 8'h9D, 8'hFF, 8'hA0};
    logic [7:0] want;
    foreach (c[i]) begin
      q = '{8'h13, c[i]};
      run();
      want = (c[i][5:0] == 6'h1C) ? 8'h10 : (c[i][7] ? 8'h0A : 8'h06);
      chk(n_rsp, 1);
      chk(rsp_byte, want);
      chk(got_exc, 1'b0);
    end
    foreach (b[i]) begin
      q = '{8'h13, b[i]};
      run();
      chk({n_rsp[0], got_exc}, 2'b01);
    end
  endtask : t_size
  task automatic t_upd_ok();
    logic [7:0] e;
    q = '{8'h12};
    add(8'h9C, 8'h0F, 32'hAABBCCDD);
    run();
    chk(wr_q.size(), 1);
    chk(wr_q[0], {6'h39, 8'h0F, 32'hAABBCCDD});
    q = '{8'h12};
    for (int j = 0; j < 42; j++) begin
      e = j[7:0];
      add(j < 29 ? e : e + 8'h63, e % 8'h06, {e + 8'h03, e + 8'h02, e + 8'h01, e});
    end
    run();
    chk({got_exc, 8'(wr_q.size())}, {1'b0, 8'd42});
    foreach (wr_q[j]) begin
      e = j[7:0];
      chk(wr_q[j], {e[5:0], e % 8'h06, e + 8'h03, e + 8'h02, e + 8'h01, e});
    end
  endtask : t_upd_ok
  task automatic t_upd_bad();
    for (int k = 0; k < 6; k++) begin
      q = '{8'h12};
      add(8'h05, 8'h00, 32'h04030201);
      case (k)
        0: add(8'h1D, 8'h00, 32'h0);
        1: add(8'h00, 8'h06, 32'h0);
        2: add(8'h9C, 8'h10, 32'h0);
        3: void'(q.pop_back());
        4: q = '{8'h12};
        default: repeat (42) add(8'h80, 8'h01, 32'h5);
      endcase
      run();
      chk(got_exc, 1'b1);
      chk(wr_q.size(), 0);
    end
  endtask : t_upd_bad
  task automatic t_load();
    q = '{8'h11, 8'hFF, 8'h85};
    run();
    chk({n_ltx[1:0], n_lrx[1:0], load_rx_code}, {4'h1, 8'h85});
    q = '{8'h11, 8'h1C, 8'hFF};
    run();
    chk({n_ltx[1:0], n_lrx[1:0], load_tx_code, got_exc}, {4'h4, 8'h1C, 1'b0});
  endtask : t_load
  // unknown code, short and long queries, refused loads
  task automatic t_misc();
    q = '{8'h16, 8'h01};
    run();
    chk({got_exc, n_rsp[0], 8'(wr_q.size())}, 10'h000);
    q = '{8'h13};
    run();
    chk({n_rsp[0], got_exc}, 2'b01);
    q = '{8'h13, 8'h85, 8'h00};
    run();
    chk({n_rsp[1:0], got_exc, rsp_byte}, {2'h1, 1'b0, 8'h0A});
    q = '{8'h11, 8'h80, 8'hFF};
    run();
    chk({n_ltx[1:0], n_lrx[1:0], got_exc}, 5'h01);
    q = '{8'h11, 8'hFF};
    run();
    chk({n_ltx[1:0], n_lrx[1:0], got_exc}, 5'h01);
  endtask : t_misc
  // reset after a completed load, then one query after release
  task automatic t_reset();
    q = '{8'h11, 8'h1C, 8'h9C};
    run();
    chk({n_ltx[1:0], n_lrx[1:0], load_tx_code, load_rx_code}, {4'h5, 16'h1C9C});
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({load_tx_code, load_rx_code}, 16'hFFFF);
    chk({exc, busy, rsp_byte}, 10'h000);
    rst_n = 1'b1;
    q = '{8'h13, 8'h9C};
    run();
    chk({n_rsp[1:0], got_exc, rsp_byte}, {2'h1, 1'b0, 8'h10});
  endtask : t_reset
  ////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    chk({busy, done, exc, rsp_valid, nv_wr_en, load_tx_go, load_rx_go}, 0);
    chk({load_tx_code, load_rx_code}, 16'hFFFF);
    rst_n = 1'b1;
    t_size();
    t_upd_ok();
    t_upd_bad();
    t_load();
    t_misc();
    t_reset();
    conclude();
  end
endmodule : tb_top

// [core/rfp_cmd_core.sv]
// Overview of operation
// - each profile code selects one fixed set
// - code 0x12 writes values into stored profiles
// - element is code, address, four value bytes
// - one to 42 elements, else exception
// - only addressed stored entries change
// - multi-byte values arrive lowest byte first
// - update code outside both ranges raises exception
// - register address must belong to profile
// - value field not four bytes raises exception
// - code 0x13 takes one profile byte
// - size query answers one count byte
// - size query bad code raises exception
// - load parameter 0xFF leaves configuration unchanged
`timescale 1ns/10ps
`include "rfp_consts.svh"

module rfp_cmd_core #(
  parameter logic [7:0] TX_REGS = 8'h08,
  parameter logic [7:0] RX_REGS = 8'h08,
  parameter logic [7:0] GT_REGS = 8'h10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command bytes from the serial front end
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  // response byte and status
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic exc,
  output logic done,
  output logic busy,
  // stored profile write port
  output logic nv_wr_en,
  output logic [5:0] nv_wr_profile,
  output logic [7:0] nv_wr_reg,
  output logic [31:0] nv_wr_data,
  // live configuration load
  output logic load_tx_go,
  output logic [7:0] load_tx_code,
  output logic load_rx_go,
  output logic [7:0] load_rx_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  // one staged update element
  typedef struct packed {
    logic [5:0] slot;
    logic [7:0] addr;
    logic [31:0] value;
  } rfp_elem_s;

  typedef struct packed {
    rfp_pkg::rfp_state_e state;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic exc;
    logic done;
    logic busy;
    logic nv_wr_en;
    logic [5:0] nv_wr_profile;
    logic [7:0] nv_wr_reg;
    logic [31:0] nv_wr_data;
    logic load_tx_go;
    logic [7:0] load_tx_code;
    logic load_rx_go;
    logic [7:0] load_rx_code;
    logic [2:0] pos;
    logic [5:0] cnt;
    logic [5:0] ptr;
    logic [7:0] cur_code;
    logic [7:0] cur_addr;
    logic err;
    // staged until rx_end so a late fault leaves storage untouched
    rfp_elem_s [41:0] elems;
  } rfp_core_s;

  rfp_core_s st;
  rfp_core_s next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  logic [7:0] map_code;
  logic map_code_ok;
  logic map_reg_ok;
  logic [5:0] map_index;
  logic [7:0] map_count;
  logic [31:0] asm_word;
  logic asm_clear;
  logic asm_valid;
  logic [31:0] elem_value;
  logic commit_last;

  // size query looks at the incoming byte, update at the held code
  assign map_code = (st.state == rfp_pkg::RFP_SIZE) ? rx_byte : st.cur_code;

  rfp_profile_map #(
    .TX_REGS(TX_REGS),
    .RX_REGS(RX_REGS),
    .GT_REGS(GT_REGS)
  ) u_map (
    .code(map_code),
    .reg_addr(st.cur_addr),
    .code_ok(map_code_ok),
    .reg_ok(map_reg_ok),
    .index(map_index),
    .reg_count(map_count)
  );

  assign asm_clear = (st.state == rfp_pkg::RFP_COLLECT) && rx_valid && (st.pos == 3'h1);
  assign asm_valid = (st.state == rfp_pkg::RFP_COLLECT) && rx_valid && (st.pos >= 3'h2);

  rfp_le_word u_word (
    .clk(clk),
    .rst_n(rst_n),
    .clear(asm_clear),
    .byte_valid(asm_valid),
    .byte_in(rx_byte),
    .word(asm_word)
  );

  // last byte is the most significant one
  assign elem_value = {rx_byte, asm_word[31:8]};

  // final staged element leaves this cycle
  assign commit_last = (st.ptr == st.cnt - 6'h01);

  // a load byte passes when it keeps its side or names a profile of that side
  function automatic logic load_ok(input logic [7:0] code, input rfp_pkg::rfp_kind_e side);
    return (code == `RFP_KEEP) || (rfp_pkg::code_kind(code) == side);
  endfunction : load_ok

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.done = 1'b0;
    next_st.nv_wr_en = 1'b0;
    next_st.load_tx_go = 1'b0;
    next_st.load_rx_go = 1'b0;
    case (st.state)
      rfp_pkg::RFP_IDLE: begin
        next_st.busy = 1'b0;
        if (rx_valid) begin
          // a new command drops the last exception
          next_st.exc = 1'b0;
          next_st.busy = 1'b1;
          next_st.pos = 3'h0;
          next_st.cnt = 6'h00;
          next_st.err = 1'b0;
          case (rx_byte)
            `RFP_CMD_UPDATE: next_st.state = rfp_pkg::RFP_COLLECT;
            `RFP_CMD_SIZE: next_st.state = rfp_pkg::RFP_SIZE;
            `RFP_CMD_LOAD: next_st.state = rfp_pkg::RFP_LOAD;
            default: next_st.state = rfp_pkg::RFP_SKIP;
          endcase
        end
      end
      rfp_pkg::RFP_COLLECT: begin
        if (rx_end) begin
          // ragged tail or empty array rejects the whole command
          if (st.err || st.pos != 3'h0 || st.cnt == 6'h00) begin
            next_st.exc = 1'b1;
            next_st.done = 1'b1;
            next_st.state = rfp_pkg::RFP_IDLE;
          end else begin
            next_st.ptr = 6'h00;
            next_st.state = rfp_pkg::RFP_COMMIT;
          end
        end else if (rx_valid) begin
          if (st.pos == `RFP_ELEM_LAST_POS) begin
            next_st.pos = 3'h0;
            // after a fault elements are parsed but never staged
            if (st.cnt == `RFP_MAX_ELEMS) begin
              next_st.err = 1'b1;
            end else if (!map_code_ok) begin
              next_st.err = 1'b1;
            end else if (!map_reg_ok) begin
              next_st.err = 1'b1;
            end else if (!st.err) begin
              next_st.elems[st.cnt] = {map_index, st.cur_addr, elem_value};
              next_st.cnt = st.cnt + 6'h01;
            end
          end else begin
            next_st.pos = st.pos + 3'h1;
            if (st.pos == 3'h0) begin
              next_st.cur_code = rx_byte;
            end else if (st.pos == 3'h1) begin
              next_st.cur_addr = rx_byte;
            end
          end
        end
      end
      rfp_pkg::RFP_COMMIT: begin
        // one stored entry per cycle, nothing else touched
        next_st.nv_wr_en = 1'b1;
        next_st.nv_wr_profile = st.elems[st.ptr].slot;
        next_st.nv_wr_reg = st.elems[st.ptr].addr;
        next_st.nv_wr_data = st.elems[st.ptr].value;
        next_st.ptr = st.ptr + 6'h01;
        if (commit_last) begin
          next_st.done = 1'b1;
          next_st.state = rfp_pkg::RFP_IDLE;
        end
      end
      rfp_pkg::RFP_SIZE: begin
        if (rx_end) begin
          next_st.exc = 1'b1;
          next_st.done = 1'b1;
          next_st.state = rfp_pkg::RFP_IDLE;
        end else if (rx_valid) begin
          if (map_code_ok) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_byte = map_count;
          end else begin
            next_st.exc = 1'b1;
          end
          // later parameter bytes are swallowed until rx_end
          next_st.state = rfp_pkg::RFP_SKIP;
        end
      end
      rfp_pkg::RFP_LOAD: begin
        if (rx_end) begin
          next_st.state = rfp_pkg::RFP_WAIT;
          if (st.pos != `RFP_LOAD_BYTES) begin
            next_st.exc = 1'b1;
          end else if (!load_ok(st.load_tx_code, rfp_pkg::RFP_KIND_TX) ||
                       !load_ok(st.load_rx_code, rfp_pkg::RFP_KIND_RX)) begin
            next_st.exc = 1'b1;
          end else begin
            next_st.load_tx_go = (st.load_tx_code != `RFP_KEEP);
            next_st.load_rx_go = (st.load_rx_code != `RFP_KEEP);
          end
        end else if (rx_valid && st.pos != `RFP_LOAD_BYTES) begin
          next_st.pos = st.pos + 3'h1;
          if (st.pos == 3'h0) begin
            next_st.load_tx_code = rx_byte;
          end else begin
            next_st.load_rx_code = rx_byte;
          end
        end else if (rx_valid) begin
          next_st.pos = 3'h3;
        end
      end
      rfp_pkg::RFP_WAIT: begin
        // load pulses leave one cycle before completion
        next_st.done = 1'b1;
        next_st.state = rfp_pkg::RFP_IDLE;
      end
      rfp_pkg::RFP_SKIP: begin
        if (rx_end) begin
          next_st.done = 1'b1;
          next_st.state = rfp_pkg::RFP_IDLE;
        end
      end
      default: begin
        next_st.state = rfp_pkg::RFP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= rfp_pkg::RFP_IDLE;
      // load codes rest at the keep value
      st.load_tx_code <= `RFP_KEEP;
      st.load_rx_code <= `RFP_KEEP;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp_valid = st.rsp_valid;
  assign rsp_byte = st.rsp_byte;
  assign exc = st.exc;
  assign done = st.done;
  assign busy = st.busy;
  assign nv_wr_en = st.nv_wr_en;
  assign nv_wr_profile = st.nv_wr_profile;
  assign nv_wr_reg = st.nv_wr_reg;
  assign nv_wr_data = st.nv_wr_data;
  assign load_tx_go = st.load_tx_go;
  assign load_tx_code = st.load_tx_code;
  assign load_rx_go = st.load_rx_go;
  assign load_rx_code = st.load_rx_code;

endmodule : rfp_cmd_core

// [core/rfp_consts.svh]
`ifndef RFP_CONSTS_SVH
`define RFP_CONSTS_SVH

// command codes
`define RFP_CMD_LOAD 8'h11
`define RFP_CMD_UPDATE 8'h12
`define RFP_CMD_SIZE 8'h13

// profile code ranges
`define RFP_TX_FIRST 8'h00
`define RFP_TX_LAST 8'h1C
`define RFP_RX_FIRST 8'h80
`define RFP_RX_LAST 8'h9C
`define RFP_TX_GENERAL 8'h1C
`define RFP_RX_GENERAL 8'h9C
`define RFP_TX_PROFILES 6'h1D

// load parameter that leaves a configuration unchanged
`define RFP_KEEP 8'hFF

// update array layout and load parameter count
`define RFP_MAX_ELEMS 6'h2A
`define RFP_ELEM_LAST_POS 3'h5
`define RFP_LOAD_BYTES 3'h2

`endif

// [core/rfp_le_word.sv]
`timescale 1ns/10ps
module rfp_le_word (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte input
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // assembled word, first byte lowest
  output logic [31:0] word
);

  typedef struct packed {
    logic [31:0] word;
  } rfp_le_s;

  rfp_le_s st;
  rfp_le_s next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.word = 32'h0000_0000;
    end else if (byte_valid) begin
      next_st.word = {byte_in, st.word[31:8]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;

endmodule : rfp_le_word

// [core/rfp_pkg.sv]
package rfp_pkg;
  `include "rfp_consts.svh"

  typedef enum logic [6:0] {
    RFP_IDLE = 7'h01,
    RFP_COLLECT = 7'h02,
    RFP_COMMIT = 7'h04,
    RFP_SIZE = 7'h08,
    RFP_LOAD = 7'h10,
    RFP_SKIP = 7'h20,
    RFP_WAIT = 7'h40
  } rfp_state_e;

  typedef enum logic [1:0] {
    RFP_KIND_NONE = 2'h0,
    RFP_KIND_TX = 2'h1,
    RFP_KIND_RX = 2'h2
  } rfp_kind_e;

  // transmitter, receiver or neither
  function automatic rfp_kind_e code_kind(input logic [7:0] code);
    if (code <= `RFP_TX_LAST) begin
      return RFP_KIND_TX;
    end else if (code >= `RFP_RX_FIRST && code <= `RFP_RX_LAST) begin
      return RFP_KIND_RX;
    end else begin
      return RFP_KIND_NONE;
    end
  endfunction : code_kind

  // stored profile slot: transmitter slots first, receiver slots after
  function automatic logic [5:0] profile_index(input logic [7:0] code);
    logic [7:0] off;
    off = code - `RFP_RX_FIRST;
    if (code_kind(code) == RFP_KIND_RX) begin
      return off[5:0] + `RFP_TX_PROFILES;
    end else begin
      return code[5:0];
    end
  endfunction : profile_index

endpackage : rfp_pkg

// [core/rfp_profile_map.sv]
`timescale 1ns/10ps
`include "rfp_consts.svh"
module rfp_profile_map #(
  parameter logic [7:0] TX_REGS = 8'h08,
  parameter logic [7:0] RX_REGS = 8'h08,
  parameter logic [7:0] GT_REGS = 8'h10
) (
  // query
  input wire logic [7:0] code,
  input wire logic [7:0] reg_addr,
  // answer
  output logic code_ok,
  output logic reg_ok,
  output logic [5:0] index,
  output logic [7:0] reg_count
);

  rfp_pkg::rfp_kind_e kind;

  always_comb begin
    kind = rfp_pkg::code_kind(code);
    code_ok = (kind != rfp_pkg::RFP_KIND_NONE);
    index = rfp_pkg::profile_index(code);
    if (!code_ok) begin
      reg_count = 8'h00;
    end else if (code == `RFP_TX_GENERAL || code == `RFP_RX_GENERAL) begin
      reg_count = GT_REGS;
    end else if (kind == rfp_pkg::RFP_KIND_TX) begin
      reg_count = TX_REGS;
    end else begin
      reg_count = RX_REGS;
    end
    reg_ok = code_ok && (reg_addr < reg_count);
  end

endmodule : rfp_profile_map
